// ==== qbp_pkg.sv ====
// Package of constants and carrier types for the quasi-bidirectional port block
package qbp_pkg;
   localparam int QBP_NUM_PORTS = 4;
   localparam int QBP_PORT_W = 8;
   localparam int QBP_STATES_PER_CYCLE = 12;
   localparam logic [7:0] QBP_LATCH_RESET = 8'h00ff;
   localparam logic [7:0] QBP_ALL_ONES = 8'h00ff;
   localparam logic [3:0] QBP_STATE_FIRST = 4'h0001;
   localparam logic [3:0] QBP_STATE_NINE = 4'h0009;
   localparam logic [3:0] QBP_STATE_TEN = 4'h000a;
   localparam logic [3:0] QBP_STATE_TWELVE = 4'h000c;
   localparam int QBP_BIT_TIMER_TWO_COUNT = 0;
   localparam int QBP_BIT_TIMER_TWO_AUX = 1;
   localparam int QBP_BIT_RXD = 0;
   localparam int QBP_BIT_TXD = 1;
   localparam int QBP_BIT_IRQ_ZERO = 2;
   localparam int QBP_BIT_IRQ_ONE = 3;
   localparam int QBP_BIT_TIMER_ZERO = 4;
   localparam int QBP_BIT_TIMER_ONE = 5;
   localparam int QBP_BIT_WRITE_N = 6;
   localparam int QBP_BIT_READ_N = 7;

   typedef enum logic [1:0] {
      QBP_PORT_ZERO,
      QBP_PORT_ONE,
      QBP_PORT_TWO,
      QBP_PORT_THREE
   } qbp_port_sel_t;

   typedef enum logic [1:0] {
      QBP_RD_NONE,
      QBP_RD_LATCH,
      QBP_RD_PIN
   } qbp_rd_kind_t;

   typedef struct packed {
      logic wr;
      qbp_port_sel_t port;
      logic [7:0] data;
   } qbp_core_wr_t;

   typedef struct packed {
      logic [7:0] addr_low_data;
      logic [7:0] addr_high;
      logic drive_data;
      logic bus_active;
      logic rd_strobe_n;
      logic wr_strobe_n;
   } qbp_ext_bus_t;

   typedef struct packed {
      logic txd;
      logic sync_data_out;
      logic sync_mode;
   } qbp_serial_out_t;

   typedef struct packed {
      logic [7:0] pull_down;
      logic [7:0] pull_up_strong;
   } qbp_drive_t;
endpackage : qbp_pkg

// ==== qbp_state_counter.sv ====
// Machine-cycle state counter, states one to twelve
module qbp_state_counter
   import qbp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   output logic [3:0] state,
   output logic last_state
);
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= QBP_STATE_FIRST;
      end else if (state == QBP_STATE_TWELVE) begin
         state <= QBP_STATE_FIRST;
      end else begin
         state <= state + 4'h0001;
      end
   end

   assign last_state = (state == QBP_STATE_TWELVE);

   state_range_a: assert property (@(posedge clk) disable iff (!resetn)
      (state >= QBP_STATE_FIRST) && (state <= QBP_STATE_TWELVE))
      else $error("Machine state out of range");
   state_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == QBP_STATE_TWELVE) |=> (state == QBP_STATE_FIRST))
      else $error("Machine state did not wrap");
endmodule : qbp_state_counter

// ==== qbp_port_block.sv ====
// Four 8-bit quasi-bidirectional I/O ports with latches, read paths and output stages
// What this block does
// - Thirty-two pins in four eight-bit ports, each pin input or output.
// - Latch bit zero turns the pull-down on, pin goes low.
// - Latch bit one releases the pull-down; weak pull-up raises ports one-three.
// - Reset loads every latch bit with one, all pins inputs.
// - Port zero open drain; strong pull-up only while serving external bus.
// - Two read paths per port: latch output or sampled pin level.
// - Read-modify-write reads take the latch; other reads take the pins.
// - Written latch value appears at state twelve of final machine cycle.
// - Output stage samples latch in first state; pin updates next cycle.
// - Pins sampled at state nine for ports zero-one, ten for two-three.
// - Reading port zero as external data bus forces its latch to ones.
// - In bus mode port zero latch forced ones, port two latch kept.
// - Output mux picks latch or bus: low address/data, high address byte.
// - Port one pins zero, one feed timer two count and aux inputs.
// - Port three pins zero, one carry serial receive/data and transmit/clock.
// - Port three pins two-five feed interrupt and timer count inputs.
// - Port three pins six, seven carry active-low write and read strobes.
module qbp_port_block
   import qbp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire qbp_core_wr_t core_wr,
   input wire qbp_port_sel_t rd_port,
   input wire qbp_rd_kind_t rd_kind,
   input wire qbp_ext_bus_t ext_bus,
   input wire qbp_serial_out_t serial_out,
   input wire logic [7:0] port_zero_in,
   input wire logic [7:0] port_one_in,
   input wire logic [7:0] port_two_in,
   input wire logic [7:0] port_three_in,
   output qbp_drive_t port_zero_drive,
   output qbp_drive_t port_one_drive,
   output qbp_drive_t port_two_drive,
   output qbp_drive_t port_three_drive,
   output logic [7:0] rd_data,
   output logic [3:0] machine_state,
   output logic timer_two_count_in,
   output logic timer_two_aux_in,
   output logic serial_rx_in,
   output logic ext_irq_zero_in,
   output logic ext_irq_one_in,
   output logic timer_zero_count_in,
   output logic timer_one_count_in
);
   logic [3:0] state;
   logic last_state;
   logic [7:0] latch [QBP_NUM_PORTS];
   logic [7:0] stage [QBP_NUM_PORTS];
   logic [7:0] pin_sample [QBP_NUM_PORTS];
   logic pend_wr;
   qbp_port_sel_t pend_port;
   logic [7:0] pend_data;
   logic [7:0] next_stage_one;
   logic [7:0] next_stage_three;

   // Output low request of a quasi-bidirectional pin set
   function automatic logic [7:0] qbp_low(input logic [7:0] lat, input logic [7:0] alt);
      qbp_low = ~(lat & alt);
   endfunction : qbp_low

   qbp_state_counter u_state (
      .clk(clk),
      .resetn(resetn),
      .state(state),
      .last_state(last_state)
   );

   // Hold a core write until state twelve
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pend_wr <= 1'b0;
         pend_port <= QBP_PORT_ZERO;
         pend_data <= QBP_LATCH_RESET;
      end else if (core_wr.wr) begin
         pend_wr <= 1'b1;
         pend_port <= core_wr.port;
         pend_data <= core_wr.data;
      end else if (last_state) begin
         pend_wr <= 1'b0;
      end
   end

   // Latches
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < QBP_NUM_PORTS; i++) begin
            latch[i] <= QBP_LATCH_RESET;
         end
      end else begin
         if (last_state && pend_wr) begin
            latch[pend_port] <= pend_data;
         end
         if (ext_bus.bus_active || (rd_kind == QBP_RD_PIN && ext_bus.bus_active)) begin
            latch[QBP_PORT_ZERO] <= QBP_ALL_ONES;
         end
      end
   end

   // Alternate outputs on port three; port one passes its latch unchanged
   always_comb begin
      next_stage_one = latch[QBP_PORT_ONE];
      next_stage_three = latch[QBP_PORT_THREE];
      next_stage_three[QBP_BIT_RXD] = latch[QBP_PORT_THREE][QBP_BIT_RXD] &
         (~serial_out.sync_mode | serial_out.sync_data_out);
      next_stage_three[QBP_BIT_TXD] = latch[QBP_PORT_THREE][QBP_BIT_TXD] & serial_out.txd;
      next_stage_three[QBP_BIT_WRITE_N] = latch[QBP_PORT_THREE][QBP_BIT_WRITE_N] &
         ext_bus.wr_strobe_n;
      next_stage_three[QBP_BIT_READ_N] = latch[QBP_PORT_THREE][QBP_BIT_READ_N] &
         ext_bus.rd_strobe_n;
   end

   // Output stage samples in the first state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < QBP_NUM_PORTS; i++) begin
            stage[i] <= QBP_LATCH_RESET;
         end
      end else if (state == QBP_STATE_FIRST) begin
         stage[QBP_PORT_ZERO] <= latch[QBP_PORT_ZERO];
         stage[QBP_PORT_ONE] <= next_stage_one;
         stage[QBP_PORT_TWO] <= latch[QBP_PORT_TWO];
         stage[QBP_PORT_THREE] <= next_stage_three;
      end
   end

   // Pin drivers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         port_zero_drive <= '0;
         port_one_drive <= '0;
         port_two_drive <= '0;
         port_three_drive <= '0;
      end else begin
         if (ext_bus.bus_active) begin
            port_zero_drive.pull_down <= ext_bus.drive_data ?
               ~ext_bus.addr_low_data : 8'h0000;
            port_zero_drive.pull_up_strong <= ext_bus.drive_data ?
               ext_bus.addr_low_data : 8'h0000;
            port_two_drive.pull_down <= ~ext_bus.addr_high;
         end else begin
            port_zero_drive.pull_down <= ~stage[QBP_PORT_ZERO];
            port_zero_drive.pull_up_strong <= 8'h0000;
            port_two_drive.pull_down <= ~stage[QBP_PORT_TWO];
         end
         port_one_drive.pull_down <= qbp_low(stage[QBP_PORT_ONE], QBP_ALL_ONES);
         port_three_drive.pull_down <= qbp_low(stage[QBP_PORT_THREE], QBP_ALL_ONES);
         port_one_drive.pull_up_strong <= 8'h0000;
         port_two_drive.pull_up_strong <= 8'h0000;
         port_three_drive.pull_up_strong <= 8'h0000;
      end
   end

   // Pin sampling; inputs must hold a full machine cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < QBP_NUM_PORTS; i++) begin
            pin_sample[i] <= QBP_LATCH_RESET;
         end
      end else begin
         if (state == QBP_STATE_NINE) begin
            pin_sample[QBP_PORT_ZERO] <= port_zero_in;
            pin_sample[QBP_PORT_ONE] <= port_one_in;
         end
         if (state == QBP_STATE_TEN) begin
            pin_sample[QBP_PORT_TWO] <= port_two_in;
            pin_sample[QBP_PORT_THREE] <= port_three_in;
         end
      end
   end

   // Read paths
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_data <= 8'h0000;
      end else begin
         case (rd_kind)
            QBP_RD_LATCH: rd_data <= latch[rd_port];
            QBP_RD_PIN: rd_data <= pin_sample[rd_port];
            QBP_RD_NONE: rd_data <= rd_data;
            default: rd_data <= rd_data;
         endcase
      end
   end

   // Alternate inputs and state out
   always_ff @(posedge clk) begin
      if (!resetn) begin
         machine_state <= QBP_STATE_FIRST;
         timer_two_count_in <= 1'b1;
         timer_two_aux_in <= 1'b1;
         serial_rx_in <= 1'b1;
         ext_irq_zero_in <= 1'b1;
         ext_irq_one_in <= 1'b1;
         timer_zero_count_in <= 1'b1;
         timer_one_count_in <= 1'b1;
      end else begin
         machine_state <= state;
         timer_two_count_in <= pin_sample[QBP_PORT_ONE][QBP_BIT_TIMER_TWO_COUNT];
         timer_two_aux_in <= pin_sample[QBP_PORT_ONE][QBP_BIT_TIMER_TWO_AUX];
         serial_rx_in <= pin_sample[QBP_PORT_THREE][QBP_BIT_RXD];
         ext_irq_zero_in <= pin_sample[QBP_PORT_THREE][QBP_BIT_IRQ_ZERO];
         ext_irq_one_in <= pin_sample[QBP_PORT_THREE][QBP_BIT_IRQ_ONE];
         timer_zero_count_in <= pin_sample[QBP_PORT_THREE][QBP_BIT_TIMER_ZERO];
         timer_one_count_in <= pin_sample[QBP_PORT_THREE][QBP_BIT_TIMER_ONE];
      end
   end

   // Checks
   latch_update_a: assert property (@(posedge clk) disable iff (!resetn)
      (last_state && pend_wr && !ext_bus.bus_active) |=>
      (latch[$past(pend_port)] == $past(pend_data)))
      else $error("Latch not updated at state twelve");
   latch_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      (!last_state && !ext_bus.bus_active) |=> $stable(latch[QBP_PORT_ONE]))
      else $error("Latch changed outside state twelve");
   stage_sample_a: assert property (@(posedge clk) disable iff (!resetn)
      (state != QBP_STATE_FIRST) |=> $stable(stage[QBP_PORT_TWO]))
      else $error("Output stage changed outside first state");
   pin_low_a: assert property (@(posedge clk) disable iff (!resetn)
      !ext_bus.bus_active |=> (port_two_drive.pull_down == ~$past(stage[QBP_PORT_TWO])))
      else $error("Port two driver does not follow stage");
   open_drain_a: assert property (@(posedge clk) disable iff (!resetn)
      !ext_bus.bus_active |=> (port_zero_drive.pull_up_strong == 8'h0000))
      else $error("Port zero pulled up outside bus mode");
   bus_force_a: assert property (@(posedge clk) disable iff (!resetn)
      ext_bus.bus_active |=> (latch[QBP_PORT_ZERO] == QBP_ALL_ONES))
      else $error("Port zero latch not forced to ones");
   bus_keep_a: assert property (@(posedge clk) disable iff (!resetn)
      (ext_bus.bus_active && !(last_state && pend_wr)) |=> $stable(latch[QBP_PORT_TWO]))
      else $error("Port two latch changed in bus mode");
   sample_nine_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == QBP_STATE_NINE) |=> (pin_sample[QBP_PORT_ONE] == $past(port_one_in)))
      else $error("Port one not sampled at state nine");
   sample_ten_a: assert property (@(posedge clk) disable iff (!resetn)
      (state != QBP_STATE_TEN) |=> $stable(pin_sample[QBP_PORT_THREE]))
      else $error("Port three sampled outside state ten");
   read_latch_a: assert property (@(posedge clk) disable iff (!resetn)
      (rd_kind == QBP_RD_LATCH) |=> (rd_data == $past(latch[rd_port])))
      else $error("Latch read path wrong");
   strobe_low_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == QBP_STATE_FIRST && !ext_bus.wr_strobe_n) |=> ##1
      port_three_drive.pull_down[QBP_BIT_WRITE_N])
      else $error("Write strobe did not pull pin low");

   // Reset values
   reset_latch_a: assert property (@(posedge clk)
      !resetn |=> (latch[QBP_PORT_THREE] == QBP_LATCH_RESET))
      else $error("Port three latch not reset to ones");
   reset_stage_a: assert property (@(posedge clk)
      !resetn |=> (stage[QBP_PORT_ONE] == QBP_LATCH_RESET))
      else $error("Port one stage not reset to ones");
   reset_release_a: assert property (@(posedge clk)
      !resetn |=> (port_one_drive.pull_down == 8'h0000))
      else $error("Port one driven low after reset");

   // Quasi-bidirectional drivers follow the stage
   port_one_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> (port_one_drive.pull_down == ~$past(stage[QBP_PORT_ONE])))
      else $error("Port one driver does not follow stage");
   port_three_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> (port_three_drive.pull_down == ~$past(stage[QBP_PORT_THREE])))
      else $error("Port three driver does not follow stage");

   // Port three alternate outputs
   txd_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == QBP_STATE_FIRST && !serial_out.txd) |=> !stage[QBP_PORT_THREE][QBP_BIT_TXD])
      else $error("Transmit output did not gate port three");
   sync_data_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == QBP_STATE_FIRST && serial_out.sync_mode && !serial_out.sync_data_out) |=> ##1
      port_three_drive.pull_down[QBP_BIT_RXD])
      else $error("Synchronous data did not pull pin low");
   async_rx_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == QBP_STATE_FIRST && !serial_out.sync_mode) |=>
      (stage[QBP_PORT_THREE][QBP_BIT_RXD] == $past(latch[QBP_PORT_THREE][QBP_BIT_RXD])))
      else $error("Receive pin not released in asynchronous mode");
   read_strobe_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == QBP_STATE_FIRST && !ext_bus.rd_strobe_n) |=> ##1
      port_three_drive.pull_down[QBP_BIT_READ_N])
      else $error("Read strobe did not pull pin low");

   // External bus output selection
   bus_high_a: assert property (@(posedge clk) disable iff (!resetn)
      ext_bus.bus_active |=> (port_two_drive.pull_down == ~$past(ext_bus.addr_high)))
      else $error("Port two does not carry high address");
   bus_low_a: assert property (@(posedge clk) disable iff (!resetn)
      (ext_bus.bus_active && ext_bus.drive_data) |=>
      (port_zero_drive.pull_down == ~$past(ext_bus.addr_low_data)))
      else $error("Port zero does not carry address or data");
   bus_pull_up_a: assert property (@(posedge clk) disable iff (!resetn)
      (ext_bus.bus_active && ext_bus.drive_data) |=>
      (port_zero_drive.pull_up_strong == $past(ext_bus.addr_low_data)))
      else $error("Port zero pull-up wrong in bus mode");
   bus_release_a: assert property (@(posedge clk) disable iff (!resetn)
      (ext_bus.bus_active && !ext_bus.drive_data) |=>
      ((port_zero_drive.pull_down | port_zero_drive.pull_up_strong) == 8'h0000))
      else $error("Port zero driven during bus input");

   // Read paths and pin sampling
   read_pin_a: assert property (@(posedge clk) disable iff (!resetn)
      (rd_kind == QBP_RD_PIN) |=> (rd_data == $past(pin_sample[rd_port])))
      else $error("Pin read path wrong");
   read_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      (rd_kind == QBP_RD_NONE) |=> $stable(rd_data))
      else $error("Read data changed without a read");
   sample_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == QBP_STATE_NINE) |=> (pin_sample[QBP_PORT_ZERO] == $past(port_zero_in)))
      else $error("Port zero not sampled at state nine");
   sample_two_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == QBP_STATE_TEN) |=> (pin_sample[QBP_PORT_TWO] == $past(port_two_in)))
      else $error("Port two not sampled at state ten");

   // Output stage timing
   stage_take_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == QBP_STATE_FIRST) |=> (stage[QBP_PORT_TWO] == $past(latch[QBP_PORT_TWO])))
      else $error("Output stage did not take latch");
   stage_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
      (state != QBP_STATE_FIRST) |=>
      ($stable(stage[QBP_PORT_ZERO]) && $stable(stage[QBP_PORT_ONE]) &&
      $stable(stage[QBP_PORT_THREE])))
      else $error("Output stages changed outside first state");

   // Pending core write
   pend_take_a: assert property (@(posedge clk) disable iff (!resetn)
      core_wr.wr |=> (pend_wr && (pend_data == $past(core_wr.data))))
      else $error("Core write not captured");
   pend_keep_a: assert property (@(posedge clk) disable iff (!resetn)
      (pend_wr && !last_state && !core_wr.wr) |=> (pend_wr && $stable(pend_data)))
      else $error("Pending write lost before state twelve");

   // Alternate inputs
   alt_timer_two_a: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=>
      ((timer_two_count_in == $past(pin_sample[QBP_PORT_ONE][QBP_BIT_TIMER_TWO_COUNT])) &&
      (timer_two_aux_in == $past(pin_sample[QBP_PORT_ONE][QBP_BIT_TIMER_TWO_AUX]))))
      else $error("Timer two inputs wrong");
   alt_rx_a: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> (serial_rx_in == $past(pin_sample[QBP_PORT_THREE][QBP_BIT_RXD])))
      else $error("Serial receive input wrong");
   alt_irq_a: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=>
      ((ext_irq_zero_in == $past(pin_sample[QBP_PORT_THREE][QBP_BIT_IRQ_ZERO])) &&
      (ext_irq_one_in == $past(pin_sample[QBP_PORT_THREE][QBP_BIT_IRQ_ONE]))))
      else $error("Interrupt inputs wrong");
   alt_timer_a: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=>
      ((timer_zero_count_in == $past(pin_sample[QBP_PORT_THREE][QBP_BIT_TIMER_ZERO])) &&
      (timer_one_count_in == $past(pin_sample[QBP_PORT_THREE][QBP_BIT_TIMER_ONE]))))
      else $error("Timer count inputs wrong");

   write_seen_c: cover property (@(posedge clk) disable iff (!resetn)
      last_state && pend_wr);
   bus_mode_c: cover property (@(posedge clk) disable iff (!resetn)
      ext_bus.bus_active && ext_bus.drive_data);
   pin_read_c: cover property (@(posedge clk) disable iff (!resetn)
      rd_kind == QBP_RD_PIN);
   latch_read_c: cover property (@(posedge clk) disable iff (!resetn)
      rd_kind == QBP_RD_LATCH);
   strobe_c: cover property (@(posedge clk) disable iff (!resetn)
      state == QBP_STATE_FIRST && !ext_bus.wr_strobe_n);
endmodule : qbp_port_block

// ==== qbp_pin_model.sv ====
// Pin-side model: external loads, weak pull-ups and the floating open-drain port
module qbp_pin_model
   import qbp_pkg::*;
(
   input wire logic clk,
   input wire qbp_drive_t drv [4],
   input wire logic [7:0] ext_low [4],
   input wire logic ext_pullup,
   output logic [7:0] pin [4]
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] flt;

   initial flt = 8'h00a5;

   // Undriven open-drain lines wander
   always @(posedge clk) begin
      flt <= ~flt;
   end

   always_comb begin
      for (int p = 0; p < 4; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (drv[p].pull_down[b] || ext_low[p][b]) begin
               pin[p][b] = 1'b0;
            end else if (p != 0 || drv[p].pull_up_strong[b] || ext_pullup) begin
               pin[p][b] = 1'b1;
            end else begin
               pin[p][b] = flt[b];
            end
         end
      end
   end
endmodule : qbp_pin_model

// ==== tb_quasi_bidir_port_block.sv ====
// Self-checking bench for the quasi-bidirectional port block
module tb_quasi_bidir_port_block
   import qbp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      qbp_port_sel_t p;
      logic [7:0] d;
      logic [7:0] x;
   } qbp_row_t;

   localparam qbp_row_t rows [4] = '{
      '{QBP_PORT_ZERO, 8'h003c, 8'h0000},
      '{QBP_PORT_ONE, 8'h00fe, 8'h0081},
      '{QBP_PORT_TWO, 8'h00a5, 8'h000f},
      '{QBP_PORT_THREE, 8'h00db, 8'h0020}
   };

   logic clk;
   logic resetn;
   qbp_core_wr_t core_wr;
   qbp_port_sel_t rd_port;
   qbp_rd_kind_t rd_kind;
   qbp_ext_bus_t ext_bus;
   qbp_serial_out_t serial_out;
   qbp_drive_t drv [4];
   logic [7:0] ext_low [4];
   logic ext_pullup;
   logic [7:0] pin [4];
   logic [7:0] rd_data;
   logic [3:0] machine_state;
   logic [6:0] alt;
   int miscompares = 0;
   int n_compared = 0;

   qbp_port_block i_qbp_port_block (
      .clk(clk), .resetn(resetn), .core_wr(core_wr), .rd_port(rd_port), .rd_kind(rd_kind),
      .ext_bus(ext_bus), .serial_out(serial_out),
      .port_zero_in(pin[0]), .port_one_in(pin[1]), .port_two_in(pin[2]),
      .port_three_in(pin[3]),
      .port_zero_drive(drv[0]), .port_one_drive(drv[1]), .port_two_drive(drv[2]),
      .port_three_drive(drv[3]), .rd_data(rd_data), .machine_state(machine_state),
      .timer_two_count_in(alt[0]), .timer_two_aux_in(alt[1]), .serial_rx_in(alt[2]),
      .ext_irq_zero_in(alt[3]), .ext_irq_one_in(alt[4]), .timer_zero_count_in(alt[5]),
      .timer_one_count_in(alt[6])
   );

   qbp_pin_model i_qbp_pin_model (
      .clk(clk), .drv(drv), .ext_low(ext_low), .ext_pullup(ext_pullup), .pin(pin)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic complete_run;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   task automatic rd(input qbp_port_sel_t p, input qbp_rd_kind_t k, input logic [7:0] exp);
      rd_port = p;
      rd_kind = k;
      tick(1);
      chk8("rd_data", exp, rd_data);
      rd_kind = QBP_RD_NONE;
      tick(1);
      chk8("rd_hold", exp, rd_data);
   endtask : rd

   task automatic write_port(input qbp_port_sel_t p, input logic [7:0] d);
      int n;
      n = 0;
      core_wr = '{1'b1, p, d};
      tick(1);
      core_wr.wr = 1'b0;
      while (drv[p].pull_down !== ~d && n < 30) begin
         tick(1);
         n++;
      end
      chk8("latency", 8'h0001, 8'(n >= 2 && n <= 13));
      if (n >= 30) begin
         complete_run();
      end
      tick(28 - n);
   endtask : write_port

   task automatic reset_check;
      chk8("machine_state", {4'h0, QBP_STATE_FIRST}, {4'h0, machine_state});
      for (int p = 0; p < 4; p++) begin
         chk8("pull_down", 8'h0000, drv[p].pull_down);
         rd(qbp_port_sel_t'(p), QBP_RD_LATCH, QBP_LATCH_RESET);
      end
   endtask : reset_check

   initial begin
      resetn = 1'b0;
      core_wr = '0;
      rd_port = QBP_PORT_ZERO;
      rd_kind = QBP_RD_NONE;
      ext_bus = '{8'h0000, 8'h0000, 1'b0, 1'b0, 1'b1, 1'b1};
      serial_out = '{1'b1, 1'b1, 1'b0};
      ext_pullup = 1'b1;
      foreach (ext_low[i]) ext_low[i] = 8'h0000;
      tick(5);
      resetn = 1'b1;
      tick(1);
      reset_check();
      chk8("alt_inputs", 8'h007f, {1'b0, alt});
      // Ordinary writes and both read paths per port
      foreach (rows[i]) begin
         ext_low[rows[i].p] = rows[i].x;
         write_port(rows[i].p, rows[i].d);
         chk8("pull_up", 8'h0000, drv[rows[i].p].pull_up_strong);
         rd(rows[i].p, QBP_RD_LATCH, rows[i].d);
         rd(rows[i].p, QBP_RD_PIN, rows[i].d & ~rows[i].x);
      end
      chk8("alt_inputs", 8'h0036, {1'b0, alt});
      // External bus mode on ports zero and two
      ext_bus = '{8'h0069, 8'h003c, 1'b1, 1'b1, 1'b1, 1'b1};
      tick(3);
      chk8("p0_pull_down", ~8'h0069, drv[0].pull_down);
      chk8("p0_pull_up", 8'h0069, drv[0].pull_up_strong);
      chk8("p2_pull_down", ~8'h003c, drv[2].pull_down);
      rd(QBP_PORT_ZERO, QBP_RD_LATCH, QBP_ALL_ONES);
      rd(QBP_PORT_TWO, QBP_RD_LATCH, 8'h00a5);
      ext_bus.drive_data = 1'b0;
      ext_bus.wr_strobe_n = 1'b0;
      ext_bus.rd_strobe_n = 1'b0;
      serial_out = '{1'b0, 1'b0, 1'b1};
      tick(14);
      chk8("p0_released", 8'h0000, drv[0].pull_down | drv[0].pull_up_strong);
      chk8("p3_pull_down", ~(8'h00db & 8'h003c), drv[3].pull_down);
      ext_bus.bus_active = 1'b0;
      ext_bus.wr_strobe_n = 1'b1;
      ext_bus.rd_strobe_n = 1'b1;
      serial_out = '{1'b1, 1'b1, 1'b0};
      tick(14);
      chk8("p0_after_bus", 8'h0000, drv[0].pull_down);
      chk8("p2_after_bus", ~8'h00a5, drv[2].pull_down);
      // Reset in mid-run
      resetn = 1'b0;
      tick(2);
      resetn = 1'b1;
      tick(1);
      reset_check();
      complete_run();
   end
endmodule : tb_quasi_bidir_port_block
